// ### cpuals_core.sv
// Execution datapath: ALU, flags, multiplier, divider, shifter, control regs
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module cpuals_core
  import cpuals_pkg::*;
#(
  parameter int NREG = 16
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire cpuals_cmd_t i_cmd,
  input  wire logic        i_cmd_valid,
  input  wire logic [15:0] i_mem_rdata,
  input  wire logic        i_irq_take,
  input  wire logic [13:0] i_repeat_count,
  input  wire logic        i_repeat_start,
  input  wire logic        i_nesting_disable,
  input  wire logic        i_pc_load,
  input  wire logic [23:0] i_pc_target,
  input  wire logic        i_pc_hold,
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_data_addr,
  output logic [15:0]      o_reg_rdata,
  output logic [15:0]      o_mem_wdata,
  output logic             o_mem_we,
  output logic             o_busy,
  output logic [23:0]      o_pc,
  output logic [23:0]      o_win_addr,
  output logic             o_win_hit,
  output logic             o_user_irq_off,
  output logic [15:0]      o_stack_ptr
);
  // Working register array
  logic [15:0] wreg [NREG];
  logic [15:0] status;
  logic [15:0] corectl;
  logic [7:0]  page;
  logic [13:0] repcnt;
  logic [PC_W-1:0] pc;
  cpuals_state_t state;
  logic [4:0]  div_cnt;
  logic [31:0] div_rq;
  logic [17:0] div_r;
  logic [15:0] div_d;
  logic        div_sq;
  logic        div_sr;
  logic        div_sgn;

  // Operand fetch
  wire logic [15:0] opa = i_cmd.mem_src ? i_mem_rdata : wreg[i_cmd.wa];
  wire logic [15:0] opb = i_cmd.use_lit ? {11'h000, i_cmd.lit} : wreg[i_cmd.wb];
  wire logic        is_sub = (i_cmd.op == CPUALS_SUB);
  wire logic [15:0] opb_x = is_sub ? ~opb : opb;

  // Adder with byte/word carry taps; borrow is inverted carry
  wire logic [16:0] sum = {1'b0, opa} + {1'b0, opb_x} + {16'h0000, is_sub};
  wire logic [8:0]  sum8 = {1'b0, opa[7:0]} + {1'b0, opb_x[7:0]} + {8'h00, is_sub};
  wire logic [4:0]  sum4 = {1'b0, opa[3:0]} + {1'b0, opb_x[3:0]} + {4'h0, is_sub};

  // Logic unit
  wire logic [15:0] logic_res = (i_cmd.op == CPUALS_AND) ? (opa & opb) :
                                (i_cmd.op == CPUALS_IOR) ? (opa | opb) :
                                (i_cmd.op == CPUALS_XOR) ? (opa ^ opb) : opa;

  // Barrel shifter: amount limited to 15, registers only
  wire logic [3:0]  shamt = opb[3:0];
  wire logic [31:0] asr_ext = {{16{wreg[i_cmd.wa][15]}}, wreg[i_cmd.wa]};
  wire logic [15:0] asr_res = 16'(asr_ext >> shamt);
  wire logic [15:0] lsr_res = wreg[i_cmd.wa] >> shamt;
  wire logic [15:0] shl_res = wreg[i_cmd.wa] << shamt;

  // 17x17 multiplier with sign extension chosen by mode
  wire logic a_sgn = (i_cmd.mmode == CPUALS_MSS) || (i_cmd.mmode == CPUALS_MSU) ||
                     (i_cmd.mmode == CPUALS_MSL);
  wire logic b_sgn = (i_cmd.mmode == CPUALS_MSS) || (i_cmd.mmode == CPUALS_MUS);
  wire logic lit_b = (i_cmd.mmode == CPUALS_MSL) || (i_cmd.mmode == CPUALS_MUL5);
  wire logic bb    = (i_cmd.mmode == CPUALS_MBB);
  wire logic [15:0] ma = bb ? {8'h00, wreg[i_cmd.wa][7:0]} : wreg[i_cmd.wa];
  wire logic [15:0] mb = lit_b ? {11'h000, i_cmd.lit} :
                         bb ? {8'h00, wreg[i_cmd.wb][7:0]} : wreg[i_cmd.wb];
  wire logic signed [16:0] ma17 = {a_sgn & ma[15], ma};
  wire logic signed [16:0] mb17 = {b_sgn & ~lit_b & mb[15], mb};
  wire logic signed [33:0] prod = ma17 * mb17;

  // Result and flag selection
  wire logic is_arith = (i_cmd.op == CPUALS_ADD) || is_sub;
  wire logic is_shift = (i_cmd.op == CPUALS_ASR) || (i_cmd.op == CPUALS_LSR) ||
                        (i_cmd.op == CPUALS_SHL);
  wire logic [15:0] res = is_arith ? sum[15:0] :
                          (i_cmd.op == CPUALS_ASR) ? asr_res :
                          (i_cmd.op == CPUALS_LSR) ? lsr_res :
                          (i_cmd.op == CPUALS_SHL) ? shl_res : logic_res;
  wire logic [15:0] res_m = i_cmd.byte_op ? {8'h00, res[7:0]} : res;
  wire logic msb_r = i_cmd.byte_op ? res[7] : res[15];
  wire logic msb_a = i_cmd.byte_op ? opa[7] : opa[15];
  wire logic msb_b = i_cmd.byte_op ? opb_x[7] : opb_x[15];
  wire logic next_c  = i_cmd.byte_op ? sum8[8] : sum[16];
  wire logic next_dc = i_cmd.byte_op ? sum4[4] : sum8[8];
  wire logic next_ov = (msb_a == msb_b) && (msb_r != msb_a);
  wire logic next_z  = (res_m == 16'h0000);
  wire logic flag_op = i_cmd_valid && (is_arith || is_shift ||
                       (i_cmd.op == CPUALS_AND) || (i_cmd.op == CPUALS_IOR) ||
                       (i_cmd.op == CPUALS_XOR));

  // Non-restoring divide step on the working remainder
  // One spare bit: a doubled partial remainder can reach twice a full-scale divisor
  wire logic [17:0] div_sh = {div_r[16:0], div_rq[31]};
  wire logic [17:0] div_nx = div_r[17] ? (div_sh + {2'b00, div_d}) : (div_sh - {2'b00, div_d});
  wire logic [15:0] dv_src = wreg[i_cmd.wb];
  wire logic [31:0] dd_src = i_cmd.div_long ?
                             {wreg[{i_cmd.wa[3:1], 1'b1}], wreg[{i_cmd.wa[3:1], 1'b0}]} :
                             (i_cmd.div_signed ? {{16{wreg[i_cmd.wa][15]}}, wreg[i_cmd.wa]}
                                               : {16'h0000, wreg[i_cmd.wa]});
  wire logic dd_neg = i_cmd.div_signed && dd_src[31];
  wire logic dv_neg = i_cmd.div_signed && dv_src[15];
  wire logic [31:0] dd_mag = dd_neg ? (32'h00000000 - dd_src) : dd_src;
  wire logic [17:0] rem_fix = div_r[17] ? (div_r + {2'b00, div_d}) : div_r;
  wire logic [15:0] q_mag = div_rq[15:0];
  wire logic [15:0] q_out = div_sq ? (16'h0000 - q_mag) : q_mag;
  wire logic [15:0] r_out = div_sr ? (16'h0000 - rem_fix[15:0]) : rem_fix[15:0];
  wire logic start_div = i_cmd_valid && (i_cmd.op == CPUALS_DIV) && (state == CPUALS_IDLE);

  // Register read decode
  wire logic [15:0] rd_val = (i_reg_addr == ADDR_STATUS)  ? (status & SR_WMASK | 16'h0010 & status) :
                             (i_reg_addr == ADDR_CORECTL) ? corectl :
                             (i_reg_addr == ADDR_PAGE)    ? {8'h00, page} :
                             (i_reg_addr == ADDR_REPCNT)  ? {2'b00, repcnt} :
                             (i_reg_addr == ADDR_PCLO)    ? pc[15:0] :
                             (i_reg_addr == ADDR_PCHI)    ? {8'h00, pc[23:16]} : 16'h0000;
  wire logic wr_sr = i_reg_wr && (i_reg_addr == ADDR_STATUS);
  wire logic [2:0] pl_wr = i_nesting_disable ? status[SR_PLL+2:SR_PLL]
                                             : i_reg_wdata[SR_PLL+2:SR_PLL];

  // Divider state machine; a taken interrupt only freezes progress
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state   <= CPUALS_IDLE;
      div_cnt <= 5'h00;
      div_rq  <= 32'h00000000;
      div_r   <= 18'h00000;
      div_d   <= 16'h0000;
      div_sq  <= 1'b0;
      div_sr  <= 1'b0;
      div_sgn <= 1'b0;
    end else begin
      case (state)
        CPUALS_IDLE: begin
          if (start_div) begin
            // Upper dividend half seeds the remainder, so 16 steps cover 32 bits
            div_rq  <= {dd_mag[15:0], 16'h0000};
            div_d   <= dv_neg ? (16'h0000 - dv_src) : dv_src;
            div_r   <= {2'b00, dd_mag[31:16]};
            div_sq  <= dd_neg ^ dv_neg;
            div_sr  <= dd_neg;
            div_sgn <= i_cmd.div_signed;
            div_cnt <= 5'h00;
            state   <= CPUALS_DIVIDE;
          end
        end
        CPUALS_DIVIDE: begin
          if (!i_irq_take) begin
            div_cnt <= div_cnt + 5'h01;
            if (div_cnt < 5'(DIV_CYCLES - 3)) begin
              if (div_cnt < 5'h10) begin
                div_r  <= div_nx;
                div_rq <= {div_rq[30:0], ~div_nx[17]};
              end
            end else begin
              state <= CPUALS_FIX;
            end
          end
        end
        CPUALS_FIX: begin
          if (!i_irq_take) begin
            div_cnt <= div_cnt + 5'h01;
            if (div_cnt == 5'(DIV_CYCLES - 1)) begin
              state <= CPUALS_IDLE;
            end
          end
        end
        default: state <= CPUALS_IDLE;
      endcase
    end
  end

  wire logic div_done = (state == CPUALS_FIX) && !i_irq_take &&
                        (div_cnt == 5'(DIV_CYCLES - 1));

  // Working register writeback: ALU, multiplier, divider
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : gen_wreg
      always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
          wreg[g] <= 16'h0000;
        end else if (div_done && (g == 0)) begin
          wreg[g] <= q_out;
        end else if (div_done && (g == 1)) begin
          wreg[g] <= r_out;
        end else if (i_cmd_valid && (i_cmd.op == CPUALS_MUL) && (state == CPUALS_IDLE)) begin
          if (g == {i_cmd.wd[3:1], 1'b0}) wreg[g] <= prod[15:0];
          else if (g == {i_cmd.wd[3:1], 1'b1}) wreg[g] <= prod[31:16];
        end else if (i_cmd_valid && !i_cmd.mem_dst && (g == i_cmd.wd) &&
                     (state == CPUALS_IDLE) && (i_cmd.op != CPUALS_NOP) &&
                     (i_cmd.op != CPUALS_DIV)) begin
          wreg[g] <= i_cmd.byte_op ? {wreg[g][15:8], res[7:0]} : res;
        end
      end
    end
  endgenerate

  // Status word: flags from ALU, software writes to writable bits
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      status <= SR_RST;
    end else begin
      if (wr_sr) begin
        status[SR_DC] <= i_reg_wdata[SR_DC];
        status[SR_PLL+2:SR_PLL] <= pl_wr;
        status[SR_N:SR_C] <= i_reg_wdata[SR_N:SR_C];
      end else if (flag_op) begin
        status[SR_N] <= msb_r;
        status[SR_Z] <= next_z;
        if (is_arith) begin
          status[SR_C]  <= next_c;
          status[SR_DC] <= next_dc;
          status[SR_OV] <= next_ov;
        end
      end
      status[SR_RA] <= (repcnt != 14'h0000) || i_repeat_start;
      status[15:9]  <= 7'h00;
    end
  end

  // Core control, window page and repeat counter
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      corectl <= CC_RST;
      page    <= 8'h00;
      repcnt  <= 14'h0000;
    end else begin
      if (i_reg_wr && (i_reg_addr == ADDR_CORECTL)) begin
        corectl <= i_reg_wdata & CC_WMASK;
      end
      if (i_reg_wr && (i_reg_addr == ADDR_PAGE)) begin
        page <= i_reg_wdata[7:0];
      end
      if (i_repeat_start) begin
        repcnt <= i_repeat_count;
      end else if ((repcnt != 14'h0000) && i_cmd_valid && !i_irq_take && !o_busy) begin
        repcnt <= repcnt - 14'h0001;
      end
    end
  end

  // Program counter: holds on multi-cycle work
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      pc <= PC_RST;
    end else if (i_pc_load) begin
      pc <= i_pc_target;
    end else if (!i_pc_hold && !o_busy && !start_div) begin
      pc <= pc + PC_STEP;
    end
  end

  // Registered outputs
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_reg_rdata    <= 16'h0000;
      o_mem_wdata    <= 16'h0000;
      o_mem_we       <= 1'b0;
      o_busy         <= 1'b0;
      o_pc           <= PC_RST;
      o_win_addr     <= 24'h000000;
      o_win_hit      <= 1'b0;
      o_user_irq_off <= 1'b0;
      o_stack_ptr    <= 16'h0000;
    end else begin
      o_reg_rdata <= i_reg_rd ? rd_val : 16'h0000;
      o_mem_wdata <= res_m;
      o_mem_we    <= i_cmd_valid && i_cmd.mem_dst && !is_shift &&
                     (state == CPUALS_IDLE) && (i_cmd.op != CPUALS_NOP);
      o_busy      <= start_div || ((state != CPUALS_IDLE) && !div_done);
      o_pc        <= pc;
      o_win_hit   <= corectl[CC_WIN] && i_data_addr[15];
      o_win_addr  <= {1'b0, page, i_data_addr[14:0]};
      o_user_irq_off <= corectl[CC_PLT] || (status[SR_PLL+2:SR_PLL] == 3'b111);
      o_stack_ptr <= wreg[NREG-1];
    end
  end
endmodule // cpuals_core
`default_nettype wire

// ### cpuals_core_monitor.sv
// Port-level property checker for the execution datapath
`timescale 1ns/100ps
`default_nettype none
module cpuals_core_chk
  import cpuals_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rstn,
  input wire cpuals_cmd_t i_cmd,
  input wire logic        i_cmd_valid,
  input wire logic        i_irq_take,
  input wire logic        i_pc_load,
  input wire logic [23:0] i_pc_target,
  input wire logic        i_pc_hold,
  input wire logic [3:0]  i_reg_addr,
  input wire logic        i_reg_rd,
  input wire logic [15:0] i_data_addr,
  input wire logic [15:0] o_reg_rdata,
  input wire logic        o_mem_we,
  input wire logic        o_busy,
  input wire logic [23:0] o_pc,
  input wire logic [23:0] o_win_addr,
  input wire logic        o_win_hit
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  logic [5:0] div_cnt;
  // A divide is accepted only while the divider is idle
  wire div_go = i_cmd_valid && (i_cmd.op == CPUALS_DIV) && !o_busy;
  // Working divide cycles; interrupt cycles freeze progress so they are skipped
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn || !o_busy) div_cnt <= 6'h00;
    else if (!i_irq_take) div_cnt <= div_cnt + 6'h01;
  end
  sequence div_run;
    o_busy [*8];
  endsequence
  rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  status_pad_a: assert property (i_reg_rd && i_reg_addr == ADDR_STATUS |=> o_reg_rdata[15:9] == 7'h00)
    else $error("unused status bits read nonzero");
  mem_write_a: assert property (i_cmd_valid && i_cmd.mem_dst && !o_busy |=> o_mem_we)
    else $error("memory write strobe missing");
  div_start_a: assert property (div_go |=> div_run)
    else $error("divider did not stay busy");
  div_len_a: assert property ($fell(o_busy) |-> div_cnt == DIV_CYCLES)
    else $error("divide length wrong");
  one_cycle_a: assert property (i_cmd_valid && i_cmd.op != CPUALS_DIV && !o_busy |=> !o_busy)
    else $error("single cycle operation stalled");
  win_hit_a: assert property (o_win_hit |-> $past(i_data_addr[15]))
    else $error("window hit on lower data half");
  win_addr_a: assert property (o_win_addr[14:0] == $past(i_data_addr[14:0]) && !o_win_addr[23])
    else $error("window address offset wrong");
  // The output copy lags the counter by one cycle, hence the two-cycle look-ahead
  pc_hold_a: assert property (i_pc_hold && !i_pc_load |-> ##2 $stable(o_pc))
    else $error("program counter moved while held");
  pc_load_a: assert property (i_pc_load |-> ##2 o_pc == $past(i_pc_target, 2))
    else $error("program counter load lost");
endmodule // cpuals_core_chk

bind cpuals_core cpuals_core_chk cpuals_core_chk_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
  .i_cmd(i_cmd), .i_cmd_valid(i_cmd_valid), .i_irq_take(i_irq_take), .i_pc_load(i_pc_load),
  .i_pc_target(i_pc_target), .i_pc_hold(i_pc_hold), .i_reg_addr(i_reg_addr),
  .i_reg_rd(i_reg_rd), .i_data_addr(i_data_addr), .o_reg_rdata(o_reg_rdata),
  .o_mem_we(o_mem_we), .o_busy(o_busy), .o_pc(o_pc), .o_win_addr(o_win_addr),
  .o_win_hit(o_win_hit));
`default_nettype wire

// ### cpuals_core_tb_top.sv
// Self-checking bench for the execution datapath
`timescale 1ns/100ps
`default_nettype none
module cpuals_core_tb_top
  import cpuals_pkg::*;
;
  logic        i_sys_clk = 1'b0, i_rstn = 1'b0, i_irq_take = 1'b0, i_repeat_start = 1'b0;
  logic        i_nesting_disable = 1'b0, i_pc_load = 1'b0, i_pc_hold = 1'b1;
  logic        i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [13:0] i_repeat_count = 14'h0000;
  logic [23:0] i_pc_target = 24'h000000;
  logic [3:0]  i_reg_addr = 4'h0;
  logic [15:0] i_reg_wdata = 16'h0000, i_data_addr = 16'h0000, st, sb, v, lo;
  wire cpuals_cmd_t cmd;
  wire logic        cmd_valid, o_mem_we, o_busy, o_win_hit, o_user_irq_off;
  wire logic [15:0] mem_rdata, o_reg_rdata, o_mem_wdata, o_stack_ptr;
  wire logic [23:0] o_pc, o_win_addr;
  int          n_fail = 0, samples_checked = 0, k;
  cpuals_cmd_t c;

  // 50 MHz clock
  always #10 i_sys_clk = ~i_sys_clk;

  cpuals_seq_model cpuals_seq_model_i (.i_sys_clk(i_sys_clk), .o_cmd(cmd),
    .o_cmd_valid(cmd_valid), .o_mem_rdata(mem_rdata));
  cpuals_core cpuals_core_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_cmd(cmd),
    .i_cmd_valid(cmd_valid), .i_mem_rdata(mem_rdata), .i_irq_take(i_irq_take),
    .i_repeat_count(i_repeat_count), .i_repeat_start(i_repeat_start),
    .i_nesting_disable(i_nesting_disable), .i_pc_load(i_pc_load), .i_pc_target(i_pc_target),
    .i_pc_hold(i_pc_hold), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_data_addr(i_data_addr),
    .o_reg_rdata(o_reg_rdata), .o_mem_wdata(o_mem_wdata), .o_mem_we(o_mem_we),
    .o_busy(o_busy), .o_pc(o_pc), .o_win_addr(o_win_addr), .o_win_hit(o_win_hit),
    .o_user_irq_off(o_user_irq_off), .o_stack_ptr(o_stack_ptr));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Register port: one-cycle strobes, read data in the following cycle only
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    rd(a, v);
    chk(32'(v), 32'(exp));
  endtask
  function automatic cpuals_cmd_t mk(cpuals_op_t op, logic [3:0] wa, wb, wd, logic ms, md);
    mk = '0;
    mk.op = op;
    mk.wa = wa;
    mk.wb = wb;
    mk.wd = wd;
    mk.mem_src = ms;
    mk.mem_dst = md;
  endfunction
  // Working registers are loaded from memory and read back through an OR to memory
  task automatic setreg(input logic [3:0] n, input logic [15:0] d);
    cpuals_seq_model_i.issue(mk(CPUALS_MOV, 4'h0, 4'h0, n, 1'b1, 1'b0), d, 0);
  endtask
  task automatic getreg(input logic [3:0] n, output logic [15:0] d);
    cpuals_seq_model_i.issue(mk(CPUALS_IOR, n, n, n, 1'b0, 1'b1), 16'h0000, 1);
    #1 d = o_mem_wdata;
  endtask
  task automatic alu(input cpuals_op_t op, input logic byt, ul, input logic [15:0] a, b, exp,
                     input logic [15:0] fm, fe);
    setreg(4'h2, a);
    setreg(4'h3, b);
    c = mk(op, 4'h2, 4'h3, 4'h4, 1'b0, 1'b0);
    c.byte_op = byt;
    c.use_lit = ul;
    c.lit = b[4:0];
    cpuals_seq_model_i.issue(c, 16'h0000, 0);
    rd(ADDR_STATUS, st);
    chk(32'(st & fm), 32'(fe));
    getreg(4'h4, v);
    chk(32'(v & (byt ? 16'h00ff : 16'hffff)), 32'(exp));
  endtask
  task automatic mul(input cpuals_mmode_t m, input logic ul, input logic [15:0] a, b,
                     input logic [31:0] exp);
    setreg(4'h2, a);
    setreg(4'h3, b);
    c = mk(CPUALS_MUL, 4'h2, 4'h3, 4'h6, 1'b0, 1'b0);
    c.mmode = m;
    c.use_lit = ul;
    c.lit = b[4:0];
    cpuals_seq_model_i.issue(c, 16'h0000, 0);
    getreg(4'h6, lo);
    getreg(4'h7, v);
    chk({v, lo}, exp);
  endtask
  // Divide: busy length counted at the edges, interrupts freeze it for nirq cycles
  task automatic div(input logic sg, lg, input logic [3:0] wa, wb, input int nirq,
                     input logic [15:0] q, r);
    c = mk(CPUALS_DIV, wa, wb, 4'h0, 1'b0, 1'b0);
    c.div_signed = sg;
    c.div_long = lg;
    cpuals_seq_model_i.issue(c, 16'h0000, 0);
    for (k = 1; k < 200; k++) begin
      @(posedge i_sys_clk);
      i_irq_take <= (k >= 3 && k < 3 + nirq);
      if (o_busy !== 1'b1) break;
    end
    // Busy was seen high on k-1 edges before the first low sample
    chk(32'(k - 1), 32'(DIV_CYCLES + nirq));
    getreg(4'h0, v);
    chk(32'(v), 32'(q));
    getreg(4'h1, v);
    chk(32'(v), 32'(r));
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    rdc(ADDR_CORECTL, 16'h0000);
    wr(ADDR_STATUS, 16'hffff);
    rdc(ADDR_STATUS, 16'h01ef);
    chk(32'(o_user_irq_off), 32'h1);
    wr(ADDR_STATUS, 16'h0000);
    wr(ADDR_CORECTL, 16'hffff);
    rdc(ADDR_CORECTL, 16'h000c);
    chk(32'(o_user_irq_off), 32'h1);
    wr(ADDR_CORECTL, 16'h0004);
    wr(ADDR_PAGE, 16'h0012);
    i_data_addr <= 16'h8abc;
    rdc(4'hf, 16'h0000);
    chk(32'(o_user_irq_off), 32'h0);
    chk(32'(o_win_addr), 32'h00090abc);
    chk(32'(o_win_hit), 32'h1);
    wr(ADDR_CORECTL, 16'h0000);
    rdc(ADDR_PAGE, 16'h0012);
    chk(32'(o_win_hit), 32'h0);
    wr(ADDR_STATUS, 16'h00e0);
    i_nesting_disable <= 1'b1;
    wr(ADDR_STATUS, 16'h0000);
    i_nesting_disable <= 1'b0;
    rdc(ADDR_STATUS, 16'h00e0);
    wr(ADDR_STATUS, 16'h0000);
    i_repeat_count <= 14'h0008;
    i_repeat_start <= 1'b1;
    @(posedge i_sys_clk);
    i_repeat_start <= 1'b0;
    rdc(ADDR_STATUS, 16'h0010);
    for (k = 0; k < 40 && v[4] !== 1'b0; k++) begin
      cpuals_seq_model_i.issue(mk(CPUALS_NOP, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0), 16'h0000, 0);
      rd(ADDR_STATUS, v);
    end
    chk(32'(v[4]), 32'h0);
    alu(CPUALS_IOR, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h000a, 16'h0002);
    alu(CPUALS_ADD, 1'b0, 1'b0, 16'h7fff, 16'h0001, 16'h8000, 16'h010f, 16'h010c);
    alu(CPUALS_ADD, 1'b0, 1'b0, 16'hffff, 16'h0001, 16'h0000, 16'h010f, 16'h0103);
    alu(CPUALS_ADD, 1'b1, 1'b0, 16'h000f, 16'h0001, 16'h0010, 16'h010f, 16'h0100);
    alu(CPUALS_SUB, 1'b0, 1'b0, 16'h0001, 16'h0002, 16'hffff, 16'h000e, 16'h0008);
    sb = st;
    alu(CPUALS_SUB, 1'b0, 1'b0, 16'h0002, 16'h0001, 16'h0001, 16'h000e, 16'h0000);
    chk(32'({sb[8], sb[0]} ^ {st[8], st[0]}), 32'h3);
    alu(CPUALS_AND, 1'b0, 1'b0, 16'hf0f0, 16'h0ff0, 16'h00f0, 16'h000a, 16'h0000);
    alu(CPUALS_XOR, 1'b0, 1'b0, 16'h8000, 16'h0000, 16'h8000, 16'h000a, 16'h0008);
    alu(CPUALS_ASR, 1'b0, 1'b0, 16'h8000, 16'h000f, 16'hffff, 16'h0000, 16'h0000);
    alu(CPUALS_LSR, 1'b0, 1'b0, 16'h8000, 16'h000f, 16'h0001, 16'h0000, 16'h0000);
    alu(CPUALS_SHL, 1'b0, 1'b1, 16'h0001, 16'h000f, 16'h8000, 16'h0000, 16'h0000);
    mul(CPUALS_MSS, 1'b0, 16'hffff, 16'hffff, 32'h00000001);
    mul(CPUALS_MUU, 1'b0, 16'hffff, 16'hffff, 32'hfffe0001);
    mul(CPUALS_MSU, 1'b0, 16'hffff, 16'h0002, 32'hfffffffe);
    mul(CPUALS_MUS, 1'b0, 16'h0002, 16'hffff, 32'hfffffffe);
    mul(CPUALS_MSL, 1'b1, 16'hffff, 16'h0003, 32'hfffffffd);
    mul(CPUALS_MUL5, 1'b1, 16'hffff, 16'h0003, 32'h0002fffd);
    mul(CPUALS_MBB, 1'b0, 16'h12ff, 16'h34ff, 32'h0000fe01);
    setreg(4'h4, 16'h0005);
    setreg(4'h5, 16'h0001);
    setreg(4'h8, 16'h0010);
    setreg(4'h9, 16'hfff9);
    setreg(4'ha, 16'h0002);
    div(1'b0, 1'b1, 4'h5, 4'h8, 2, 16'h1000, 16'h0005);
    div(1'b1, 1'b0, 4'h9, 4'ha, 0, 16'hfffd, 16'hffff);
    setreg(4'hf, 16'h1ffe);
    i_pc_target <= 24'hfffffe;
    i_pc_load <= 1'b1;
    @(posedge i_sys_clk);
    i_pc_load <= 1'b0;
    @(posedge i_sys_clk);
    #1 chk(32'(o_stack_ptr), 32'h1ffe);
    chk(32'(o_pc), 32'h00fffffe);
    @(posedge i_sys_clk);
    i_pc_hold <= 1'b0;
    @(posedge i_sys_clk);
    i_pc_hold <= 1'b1;
    @(posedge i_sys_clk);
    #1 chk(32'(o_pc), 32'h00000000);
    wrap_up();
  end
endmodule // cpuals_core_tb_top
`default_nettype wire

// ### cpuals_pkg.sv
// Shared constants, types and field layout of the execution datapath
`default_nettype none
package cpuals_pkg;
  // Register map of the plain register port
  localparam logic [3:0] ADDR_STATUS  = 4'h0;
  localparam logic [3:0] ADDR_CORECTL = 4'h1;
  localparam logic [3:0] ADDR_PAGE    = 4'h2;
  localparam logic [3:0] ADDR_REPCNT  = 4'h3;
  localparam logic [3:0] ADDR_PCLO    = 4'h4;
  localparam logic [3:0] ADDR_PCHI    = 4'h5;
  // Status word fields
  localparam int SR_C   = 0;
  localparam int SR_Z   = 1;
  localparam int SR_OV  = 2;
  localparam int SR_N   = 3;
  localparam int SR_RA  = 4;
  localparam int SR_PLL = 5;
  localparam int SR_DC  = 8;
  localparam logic [15:0] SR_WMASK = 16'h01ef;
  localparam logic [15:0] SR_RST   = 16'h0000;
  // Core control fields
  localparam int CC_WIN = 2;
  localparam int CC_PLT = 3;
  localparam logic [15:0] CC_WMASK = 16'h000c;
  localparam logic [15:0] CC_RST   = 16'h0000;
  // Timing and widths
  localparam int DIV_CYCLES = 19;
  localparam int PC_W       = 24;
  localparam logic [PC_W-1:0] PC_RST  = 24'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 24'h000002;
  localparam logic [15:0] WIN_BASE    = 16'h8000;

  // Operations issued by the sequencer
  typedef enum logic [3:0] {
    CPUALS_NOP = 4'b0000, CPUALS_ADD = 4'b0001, CPUALS_SUB = 4'b0010,
    CPUALS_AND = 4'b0011, CPUALS_IOR = 4'b0100, CPUALS_XOR = 4'b0101,
    CPUALS_MUL = 4'b0110, CPUALS_DIV = 4'b0111, CPUALS_ASR = 4'b1000,
    CPUALS_LSR = 4'b1001, CPUALS_SHL = 4'b1010, CPUALS_MOV = 4'b1011
  } cpuals_op_t;

  // Multiply modes: a-operand sign, b-operand sign, width
  typedef enum logic [2:0] {
    CPUALS_MSS = 3'b000, CPUALS_MUU = 3'b001, CPUALS_MSU = 3'b010,
    CPUALS_MUS = 3'b011, CPUALS_MSL = 3'b100, CPUALS_MUL5 = 3'b101,
    CPUALS_MBB = 3'b110
  } cpuals_mmode_t;

  typedef enum logic [1:0] {
    CPUALS_IDLE = 2'b00, CPUALS_DIVIDE = 2'b01, CPUALS_FIX = 2'b10
  } cpuals_state_t;

  // One issued instruction
  typedef struct packed {
    cpuals_op_t    op;
    logic          byte_op;
    logic          div_signed;
    logic          div_long;
    cpuals_mmode_t mmode;
    logic          use_lit;
    logic [4:0]    lit;
    logic [3:0]    wa;
    logic [3:0]    wb;
    logic [3:0]    wd;
    logic          mem_src;
    logic          mem_dst;
  } cpuals_cmd_t;
endpackage
`default_nettype wire

// ### cpuals_seq_model.sv
// Behavioural instruction sequencer and data memory read port
`timescale 1ns/100ps
`default_nettype none
module cpuals_seq_model
  import cpuals_pkg::*;
(
  input  wire logic       i_sys_clk,
  output var cpuals_cmd_t o_cmd,
  output logic            o_cmd_valid,
  output logic [15:0]     o_mem_rdata
);
  // Idle outputs from time zero
  initial begin
    o_cmd = '0;
    o_cmd_valid = 1'b0;
    o_mem_rdata = 16'h0000;
  end
  // One instruction per call, optional lag; stale fields are scrambled afterwards
  task automatic issue(input cpuals_cmd_t c, input logic [15:0] md, input int lag);
    repeat (lag) @(posedge i_sys_clk);
    @(posedge i_sys_clk);
    o_cmd <= c;
    o_mem_rdata <= md;
    o_cmd_valid <= 1'b1;
    @(posedge i_sys_clk);
    o_cmd_valid <= 1'b0;
    o_cmd <= ~c;
    o_mem_rdata <= ~md;
  endtask
endmodule // cpuals_seq_model
`default_nettype wire
